// ===== hdl/msgp_gpio.sv
// The APB register port was chosen for this implementation.
module msgp_gpio
	import msgp_pkg::*;
#(
	parameter int PORT_W = 8
)
(
	input  wire logic        core_clk,       // Core clock, 125 MHz
	input  wire logic        rst_b,          // Async reset, active low
	input  wire logic        por_b,          // Power-on/brown-out, low
	input  wire logic        psel,           // APB select
	input  wire logic        penable,        // APB access phase
	input  wire logic        pwrite,         // APB direction
	input  wire logic [11:0] paddr,          // APB byte address
	input  wire logic [31:0] pwdata,         // APB write data
	output logic      [31:0] prdata,         // APB read data
	output logic             pready,         // APB ready
	output logic             pslverr,        // APB error
	input  wire logic [7:0]  first_pin_in,   // First-port pin levels
	output logic      [7:0]  first_pin_out,  // First-port drive value
	output logic      [7:0]  first_pin_oe,   // First-port drive enable
	input  wire logic [7:0]  second_pin_in,  // Second-port pin levels
	output logic      [7:0]  second_pin_out, // Second-port drive value
	output logic      [7:0]  second_pin_oe,  // Second-port drive enable
	output logic      [7:0]  pullup_en,      // Weak pull-up enables
	output logic      [5:0]  analog_sel,     // Analog mode per pin
	output logic             timer_ext_clock_in, // Timer clock feed
	output logic             osc_pins_en,    // Pins 6,7 to oscillator
	output logic             change_irq,     // Port-change request
	output logic             wake_req        // Wake from sleep
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	// eight bits
	if (PORT_W != 8)
	begin : g_bad_width
		$error("msgp_gpio supports only eight-bit ports");
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] first_lat_reg;
	logic [3:0] first_hi_reg;
	logic [3:0] first_lo_reg;
	logic [7:0] first_dir_reg;
	logic [5:0] analog_pin_select_reg;
	logic [7:0] second_lat_reg;
	logic [7:0] second_dir_reg;
	logic [7:0] pullup_mask_reg;
	logic [7:0] chg_mask_reg;
	logic [7:0] option_reg;
	logic       chg_en_reg;
	logic       chg_flag_reg;
	logic       osc_reg;
	logic [7:0] chg_snap_reg;

	logic [7:0] first_rd;
	logic [7:0] second_rd;
	logic [7:0] mismatch;
	logic [7:0] widx;
	logic       acc;
	logic       wr;
	logic       rd;
	logic       hit;
	logic [7:0] rdata_next;
	msgp_pins_t first_drv;
	msgp_pins_t second_drv;

	assign widx = paddr[9:2];
	assign acc  = psel && penable;
	assign wr   = acc && pwrite;
	assign rd   = acc && !pwrite;

	// ----------------------------------------------------------------
	// Pin read path with analog masking
	// ----------------------------------------------------------------
	// select mapping
	always_comb
	begin
		first_rd  = first_pin_in;
		second_rd = second_pin_in;
		for (int i = 0; i < FIRST_ANA_PINS; i++)
		begin
			if (analog_pin_select_reg[i])
				first_rd[i] = 1'b0;
		end
		for (int i = FIRST_ANA_PINS; i < ANALOG_PIN_SELECT_BITS; i++)
		begin
			if (analog_pin_select_reg[i])
				second_rd[i - FIRST_ANA_PINS] = 1'b1;
		end
		// Oscillator-owned pins give no port value
		if (osc_reg)
		begin
			first_rd[OSC_OUT_PIN] = 1'b0;
			first_rd[OSC_IN_PIN]  = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive logic, one entry per pin
	// ----------------------------------------------------------------
	// direction drive
	// pull-up gating
	// One assignment per bit, so no two processes share a variable
	genvar g;
	for (g = 0; g < 8; g++)
	begin : g_pin
		assign second_drv.out[g] = second_lat_reg[g];
		assign second_drv.oe[g]  = !second_dir_reg[g];
		assign first_drv.out[g]  = (g == ODRAIN_PIN) ? 1'b0
			: first_lat_reg[g];
		assign first_drv.oe[g]   = (g == INPUT_ONLY_PIN) ? 1'b0
			: ((g == OSC_OUT_PIN || g == OSC_IN_PIN) && osc_reg) ? 1'b0
			: (g == ODRAIN_PIN) ? (!first_dir_reg[g] && !first_lat_reg[g])
			: !first_dir_reg[g];
	end

	assign mismatch = (second_rd ^ chg_snap_reg) & chg_mask_reg
		& second_dir_reg;

	// ----------------------------------------------------------------
	// Registered pin outputs
	// ----------------------------------------------------------------
	// pull-ups off
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			first_pin_out  <= RST_ZERO;
			first_pin_oe   <= RST_ZERO;
			second_pin_out <= RST_ZERO;
			second_pin_oe  <= RST_ZERO;
			pullup_en      <= RST_ZERO;
			analog_sel     <= RST_ANALOG_PIN_SELECT;
			timer_ext_clock_in <= 1'b0;
			osc_pins_en    <= 1'b0;
		end
		else
		begin
			first_pin_out  <= first_drv.out;
			first_pin_oe   <= first_drv.oe;
			second_pin_out <= second_drv.out;
			second_pin_oe  <= second_drv.oe;
			pullup_en      <= option_reg[PULLUP_OFF_BIT] ? RST_ZERO
				: (pullup_mask_reg & second_dir_reg);
			analog_sel     <= analog_pin_select_reg;
			// Schmitt input feeds the timer regardless of direction
			timer_ext_clock_in <= first_pin_in[ODRAIN_PIN];
			osc_pins_en    <= osc_reg;
		end
	end

	// ----------------------------------------------------------------
	// First-port latch and direction
	// ----------------------------------------------------------------
	// reset values
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			first_lo_reg  <= LOW_NIBBLE_CLR;
			first_dir_reg <= RST_DIR;
		end
		else if (!por_b)
		begin
			first_lo_reg  <= RST_FIRST_LAT_POR[3:0];
			first_dir_reg <= RST_DIR;
		end
		else if (wr && widx == IDX_FIRST_PORT_DATA)
			first_lo_reg <= pwdata[3:0];
		else if (wr && widx == IDX_FIRST_PORT_DIR)
			first_dir_reg <= pwdata[7:0];
	end

	// Upper half has no general reset, so it keeps its value there;
	// only power-on clears it, the one case where it may be anything
	always_ff @(posedge core_clk)
	begin
		if (!por_b)
			first_hi_reg <= RST_FIRST_LAT_POR[7:4];
		else if (wr && widx == IDX_FIRST_PORT_DATA)
			first_hi_reg <= pwdata[7:4];
	end

	// Whole latch as the pin drivers see it
	assign first_lat_reg = {first_hi_reg, first_lo_reg};

	// ----------------------------------------------------------------
	// Analog select and configuration
	// ----------------------------------------------------------------
	// power-on analog
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			analog_pin_select_reg       <= RST_ANALOG_PIN_SELECT;
			second_dir_reg  <= RST_DIR;
			second_lat_reg  <= RST_ZERO;
			pullup_mask_reg <= RST_ZERO;
			chg_mask_reg    <= RST_ZERO;
			option_reg      <= RST_OPTION;
			chg_en_reg      <= 1'b0;
			osc_reg         <= 1'b0;
		end
		else if (!por_b)
		begin
			analog_pin_select_reg  <= RST_ANALOG_PIN_SELECT;
			option_reg <= RST_OPTION;
		end
		else if (wr)
		begin
			case (widx)
				IDX_ANALOG_PIN_SEL:   analog_pin_select_reg <= pwdata[5:0];
				IDX_SECOND_PORT_DATA: second_lat_reg <= pwdata[7:0];
				IDX_SECOND_PORT_DIR:  second_dir_reg <= pwdata[7:0];
				IDX_PULLUP_MASK:      pullup_mask_reg <= pwdata[7:0];
				IDX_CHANGE_IRQ_MASK:  chg_mask_reg <= pwdata[7:0];
				IDX_OPTION_CTRL:      option_reg <= pwdata[7:0];
				IDX_INT_CONTROL:      chg_en_reg <= pwdata[CHG_EN_BIT];
				IDX_CLOCK_CFG:        osc_reg <= pwdata[OSC_PINS_BIT];
				default:              chg_en_reg <= chg_en_reg;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Change detect
	// ----------------------------------------------------------------
	// snapshot reload
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			chg_snap_reg <= RST_ZERO;
		else if (acc && widx == IDX_SECOND_PORT_DATA)
			chg_snap_reg <= second_rd;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			chg_flag_reg <= 1'b0;
		else if (|mismatch)
			chg_flag_reg <= 1'b1;
		else if (wr && widx == IDX_INT_CONTROL)
			chg_flag_reg <= pwdata[CHG_FLAG_BIT];
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			change_irq <= 1'b0;
			wake_req   <= 1'b0;
		end
		else
		begin
			change_irq <= chg_flag_reg && chg_en_reg;
			wake_req   <= chg_flag_reg && chg_en_reg;
		end
	end

	// ----------------------------------------------------------------
	// APB read data, zero wait states
	// ----------------------------------------------------------------
	always_comb
	begin
		hit        = 1'b1;
		rdata_next = RST_ZERO;
		case (widx)
			IDX_FIRST_PORT_DATA:  rdata_next = first_rd;
			IDX_FIRST_PORT_DIR:   rdata_next = first_dir_reg;
			IDX_ANALOG_PIN_SEL:   rdata_next = {2'b00, analog_pin_select_reg};
			IDX_SECOND_PORT_DATA: rdata_next = second_rd;
			IDX_SECOND_PORT_DIR:  rdata_next = second_dir_reg;
			IDX_PULLUP_MASK:      rdata_next = pullup_mask_reg;
			IDX_CHANGE_IRQ_MASK:  rdata_next = chg_mask_reg;
			IDX_OPTION_CTRL:      rdata_next = option_reg;
			IDX_INT_CONTROL:      rdata_next = {4'h0, chg_en_reg, 2'b00,
				chg_flag_reg};
			IDX_CLOCK_CFG:        rdata_next = {7'h00, osc_reg};
			default:              hit = 1'b0;
		endcase
		if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00)
			hit = 1'b0;
	end

	// Answer registered in setup, so access ends in one cycle
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prdata  <= BUS_ZERO;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			prdata  <= (psel && !penable && !pwrite && hit)
				? {24'h000000, rdata_next} : BUS_ZERO;
		end
	end

	logic unused_rd;
	assign unused_rd = rd;

endmodule

// ===== hdl/msgp_pkg.sv
package msgp_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_FIRST_PORT_DATA  = 8'h05;
	localparam logic [7:0] IDX_FIRST_PORT_DIR   = 8'h85;
	localparam logic [7:0] IDX_ANALOG_PIN_SEL   = 8'h9D;
	localparam logic [7:0] IDX_SECOND_PORT_DATA = 8'h06;
	localparam logic [7:0] IDX_SECOND_PORT_DIR  = 8'h86;
	localparam logic [7:0] IDX_PULLUP_MASK      = 8'h95;
	localparam logic [7:0] IDX_CHANGE_IRQ_MASK  = 8'h96;
	localparam logic [7:0] IDX_INT_CONTROL      = 8'h0B;
	localparam logic [7:0] IDX_OPTION_CTRL      = 8'h81;
	localparam logic [7:0] IDX_CLOCK_CFG        = 8'h8F;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         ANALOG_PIN_SELECT_BITS        = 6;
	localparam int         FIRST_ANA_PINS    = 4;
	localparam int         CHG_FLAG_BIT      = 0;
	localparam int         CHG_EN_BIT        = 3;
	localparam int         PULLUP_OFF_BIT    = 7;
	localparam int         OSC_PINS_BIT      = 0;
	localparam int         ODRAIN_PIN        = 4;
	localparam int         INPUT_ONLY_PIN    = 5;
	localparam int         OSC_OUT_PIN       = 6;
	localparam int         OSC_IN_PIN        = 7;
	localparam logic [7:0] RST_DIR           = 8'hFF;
	localparam logic [5:0] RST_ANALOG_PIN_SELECT         = 6'h3F;
	localparam logic [7:0] RST_FIRST_LAT_POR = 8'h00;
	localparam logic [3:0] LOW_NIBBLE_CLR    = 4'h0;
	localparam logic [7:0] RST_OPTION        = 8'hFF;
	localparam logic [7:0] RST_ZERO          = 8'h00;
	localparam logic [31:0] BUS_ZERO         = 32'h0000_0000;

	// Per-pin controls of one port travel together
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} msgp_pins_t;

endpackage

// ===== tb/msgp_gpio_props.sv
module msgp_gpio_props
	import msgp_pkg::*;
(
	input wire logic        core_clk,           // Core clock
	input wire logic        rst_b,              // Async reset, low
	input wire logic        psel,               // APB select
	input wire logic        penable,            // APB access phase
	input wire logic        pwrite,             // APB direction
	input wire logic [11:0] paddr,              // APB address
	input wire logic [31:0] pwdata,             // APB write data
	input wire logic        pready,             // APB ready
	input wire logic [7:0]  first_pin_in,       // First-port levels
	input wire logic [7:0]  first_pin_out,      // First-port drive
	input wire logic [7:0]  first_pin_oe,       // First-port enable
	input wire logic [7:0]  second_pin_oe,      // Second-port enable
	input wire logic [7:0]  pullup_en,          // Pull-up enables
	input wire logic        timer_ext_clock_in, // Timer clock feed
	input wire logic        change_irq,         // Change request
	input wire logic        wake_req            // Wake request
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Bus phases; direction write is two steps from its effect on pins
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence dir_wr_s;
		psel && penable && pwrite
			&& paddr == {2'b00, IDX_FIRST_PORT_DIR, 2'b00};
	endsequence

	apb_ready_a: assert property (setup_s |=> pready)
		else $error("pready missing after setup");
	ready_once_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	input_only_a: assert property (!first_pin_oe[INPUT_ONLY_PIN])
		else $error("input-only pin driven");
	odrain_high_a: assert property (!first_pin_out[ODRAIN_PIN])
		else $error("open-drain pin drives high");
	pullup_out_a: assert property (
		(pullup_en & second_pin_oe) == 8'h00)
		else $error("pull-up on an output pin");
	wake_irq_a: assert property (wake_req == change_irq)
		else $error("wake request differs from change request");
	timer_feed_a: assert property (
		$rose(first_pin_in[ODRAIN_PIN]) |=> timer_ext_clock_in)
		else $error("timer clock feed missed a rise");
	dir_drive_a: assert property (dir_wr_s |->
		##2 first_pin_oe[3:0] == ~$past(pwdata[3:0], 2))
		else $error("direction write not on drivers");
endmodule

bind msgp_gpio msgp_gpio_props i_props (.core_clk, .rst_b, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .first_pin_in, .first_pin_out,
	.first_pin_oe, .second_pin_oe, .pullup_en, .timer_ext_clock_in,
	.change_irq, .wake_req);

// ===== tb/msgp_pin_model.sv
module msgp_pin_model
	import msgp_pkg::*;
(
	input wire logic       core_clk,   // Core clock
	input wire msgp_pins_t first_drv,  // Device first-port drive
	input wire msgp_pins_t second_drv, // Device second-port drive
	input wire logic [7:0] pullup_en,  // Weak pull-ups
	input wire msgp_pins_t first_ext,  // Board first-port drive
	input wire msgp_pins_t second_ext, // Board second-port drive
	output logic     [7:0] first_lvl,  // First-port wire levels
	output logic     [7:0] second_lvl  // Second-port wire levels
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] first_last = 8'h00;
	logic [7:0] second_last = 8'h00;

	// Device, then board, then pull-up; a floating wire flips each cycle
	function automatic logic [7:0] res(msgp_pins_t d, msgp_pins_t e,
		logic [7:0] pu, logic [7:0] last);
		for (int i = 0; i < 8; i++)
			res[i] = d.oe[i] ? d.out[i] : e.oe[i] ? e.out[i]
				: pu[i] ? 1'b1 : ~last[i];
	endfunction

	assign first_lvl = res(first_drv, first_ext, 8'h00, first_last);
	assign second_lvl = res(second_drv, second_ext, pullup_en, second_last);

	// Memory of the last level, so no stale value survives release
	always_ff @(posedge core_clk)
	begin
		first_last <= first_lvl;
		second_last <= second_lvl;
	end
endmodule

// ===== tb/tb_top.sv
module tb_top
	import msgp_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst_b = 0, por_b = 1;
	logic psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, timer_ext_clock_in;
	logic osc_pins_en, change_irq, wake_req;
	logic [7:0] first_pin_in, first_pin_out, first_pin_oe, pullup_en;
	logic [7:0] second_pin_in, second_pin_out, second_pin_oe, q;
	logic [5:0] analog_sel;
	logic err;
	msgp_pins_t ext1 = '{out: 8'hFF, oe: 8'hFF};
	msgp_pins_t ext2 = '{out: 8'h3C, oe: 8'hFF};
	int n_fail = 0, check_count = 0, cyc = 0;

	msgp_gpio i_dut (.core_clk, .rst_b, .por_b, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .first_pin_in,
		.first_pin_out, .first_pin_oe, .second_pin_in, .second_pin_out,
		.second_pin_oe, .pullup_en, .analog_sel, .timer_ext_clock_in,
		.osc_pins_en, .change_irq, .wake_req);
	msgp_pin_model i_pins (.core_clk, .pullup_en,
		.first_drv({first_pin_out, first_pin_oe}),
		.second_drv({second_pin_out, second_pin_oe}),
		.first_ext(ext1), .second_ext(ext2),
		.first_lvl(first_pin_in), .second_lvl(second_pin_in));

	// Clock, 8 ns period
	always #4 core_clk = ~core_clk;

	// Hang guard, far above the roughly 140 cycles the run needs
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			n_fail++;
			print_verdict;
		end
	end

	function automatic logic [11:0] ad(logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction

	// One APB transfer; values read just after the edge are pre-edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [7:0] r);
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge core_clk);
		penable <= 1;
		// Only the bench timeout ends a wait on a silent slave
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		r = prdata[7:0];
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	task automatic t_reset;
		apb(0, ad(IDX_FIRST_PORT_DIR), 8'h00, q);
		chk("first dir", 8'hFF, q);
		apb(0, ad(IDX_ANALOG_PIN_SEL), 8'h00, q);
		chk("analog sel", 8'h3F, q);
		apb(0, ad(IDX_FIRST_PORT_DATA), 8'h00, q);
		chk("first pins", 8'hF0, q);
		apb(0, ad(IDX_SECOND_PORT_DATA), 8'h00, q);
		chk("second pins", 8'h3F, q);
		chk("pullups", 8'h00, pullup_en);
		chk("analog out", 8'h3F, {2'b00, analog_sel});
		apb(0, 12'h000, 8'h00, q);
		chk("unmapped err", 8'h01, {7'h00, err});
		$display("test reset done");
	endtask

	task automatic t_drive;
		ext1 <= '{out: 8'hFF, oe: 8'h20};
		apb(1, ad(IDX_ANALOG_PIN_SEL), 8'h00, q);
		apb(1, ad(IDX_FIRST_PORT_DIR), 8'h00, q);
		apb(1, ad(IDX_FIRST_PORT_DATA), 8'hA5, q);
		repeat (2) @(posedge core_clk);
		chk("first oe", 8'hDF, first_pin_oe);
		chk("first out", 8'h85, first_pin_out & 8'hDF);
		apb(0, ad(IDX_FIRST_PORT_DATA), 8'h00, q);
		chk("first read", 8'hA5, q);
		apb(1, ad(IDX_ANALOG_PIN_SEL), 8'h01, q);
		apb(0, ad(IDX_FIRST_PORT_DATA), 8'h00, q);
		chk("analog bit", 8'hA4, q);
		chk("analog drive", 8'hDF, first_pin_oe);
		apb(1, ad(IDX_FIRST_PORT_DIR), 8'hFF, q);
		repeat (2) @(posedge core_clk);
		chk("inputs", 8'h00, first_pin_oe);
		ext1 <= '{out: 8'hFF, oe: 8'hFF};
		$display("test drive done");
	endtask

	task automatic t_por;
		apb(1, ad(IDX_FIRST_PORT_DATA), 8'hC5, q);
		rst_b <= 0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1;
		apb(1, ad(IDX_FIRST_PORT_DIR), 8'h00, q);
		repeat (2) @(posedge core_clk);
		chk("kept upper", 8'hC0, first_pin_out & 8'hCF);
		apb(1, ad(IDX_ANALOG_PIN_SEL), 8'h00, q);
		por_b <= 0;
		@(posedge core_clk);
		por_b <= 1;
		repeat (3) @(posedge core_clk);
		chk("por dir", 8'h00, first_pin_oe);
		apb(0, ad(IDX_ANALOG_PIN_SEL), 8'h00, q);
		chk("por analog", 8'h3F, q);
		apb(1, ad(IDX_CLOCK_CFG), 8'h01, q);
		repeat (2) @(posedge core_clk);
		chk("osc pins", 8'h01, {7'h00, osc_pins_en});
		$display("test resets done");
	endtask

	task automatic t_pullup;
		ext2 <= '{out: 8'h00, oe: 8'h00};
		apb(1, ad(IDX_ANALOG_PIN_SEL), 8'h00, q);
		apb(1, ad(IDX_PULLUP_MASK), 8'hFF, q);
		apb(1, ad(IDX_SECOND_PORT_DIR), 8'h0F, q);
		apb(1, ad(IDX_SECOND_PORT_DATA), 8'hA0, q);
		repeat (2) @(posedge core_clk);
		chk("pullup global", 8'h00, pullup_en);
		chk("second out", 8'hA0, second_pin_out);
		chk("second oe", 8'hF0, second_pin_oe);
		apb(1, ad(IDX_OPTION_CTRL), 8'h7F, q);
		repeat (2) @(posedge core_clk);
		chk("pullup inputs", 8'h0F, pullup_en);
		apb(1, ad(IDX_OPTION_CTRL), 8'hFF, q);
		apb(1, ad(IDX_SECOND_PORT_DIR), 8'hFF, q);
		ext2 <= '{out: 8'h00, oe: 8'hFF};
		$display("test pullup done");
	endtask

	// No polling of the port while waiting for a change
	task automatic t_change;
		apb(1, ad(IDX_CHANGE_IRQ_MASK), 8'h10, q);
		apb(1, ad(IDX_INT_CONTROL), 8'h08, q);
		apb(0, ad(IDX_SECOND_PORT_DATA), 8'h00, q);
		chk("snapshot", 8'h00, q);
		ext2 <= '{out: 8'h20, oe: 8'hFF};
		repeat (4) @(posedge core_clk);
		chk("unselected", 8'h00, {7'h00, change_irq});
		ext2 <= '{out: 8'h30, oe: 8'hFF};
		repeat (4) @(posedge core_clk);
		chk("change irq", 8'h01, {7'h00, change_irq});
		chk("wake", 8'h01, {7'h00, wake_req});
		apb(1, ad(IDX_INT_CONTROL), 8'h08, q);
		apb(0, ad(IDX_INT_CONTROL), 8'h00, q);
		chk("flag held", 8'h09, q & 8'h09);
		apb(0, ad(IDX_SECOND_PORT_DATA), 8'h00, q);
		apb(1, ad(IDX_INT_CONTROL), 8'h08, q);
		apb(0, ad(IDX_INT_CONTROL), 8'h00, q);
		chk("flag clear", 8'h08, q & 8'h09);
		apb(1, ad(IDX_INT_CONTROL), 8'h00, q);
		ext2 <= '{out: 8'h00, oe: 8'hFF};
		repeat (4) @(posedge core_clk);
		chk("gated", 8'h00, {7'h00, change_irq});
		$display("test change done");
	endtask

	task automatic print_verdict;
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Main sequence after ten cycles of reset
	initial
	begin
		repeat (10) @(posedge core_clk);
		rst_b <= 1;
		t_reset;
		t_drive;
		t_por;
		t_pullup;
		t_change;
		print_verdict;
	end
endmodule
